//--- gas_averager.sv
// Sample accumulator and averaging divider
module gas_averager
  import gas_pkg::*;
(
  input  wire logic                 mclk_in,
  input  wire logic                 arst_n_in,
  input  wire logic                 clear_in,
  input  wire logic                 start_in,
  input  wire logic [1:0]           avg_code_in,
  input  wire logic                 sample_valid_in,
  input  wire logic [RES_WIDTH-1:0] sample_in,
  output logic                      last_out,
  output logic [RES_WIDTH-1:0]      avg_out
);

  logic [2:0]           shift_q;
  logic [4:0]           cnt_q;
  logic [SUM_WIDTH-1:0] sum_q;
  logic [SUM_WIDTH-1:0] sum_d;
  logic [SUM_WIDTH-1:0] quot;
  logic [RES_WIDTH-1:0] avg_q;

  assign sum_d    = sum_q + {4'h0, sample_in};
  assign quot     = sum_d >> shift_q;
  assign last_out = (cnt_q == ((5'h01 << shift_q) - 5'h01));
  assign avg_out  = avg_q;

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      shift_q <= 3'h0;
      cnt_q   <= 5'h00;
      sum_q   <= 14'h0000;
    end else if (clear_in || start_in) begin
      shift_q <= start_in ? gas_avg_shift(avg_code_in) : 3'h0;
      cnt_q   <= 5'h00;
      sum_q   <= 14'h0000;
    end else if (sample_valid_in) begin
      cnt_q <= cnt_q + 5'h01;
      sum_q <= sum_d;
    end
  end

  // Quotient latched with the final sample
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      avg_q <= 10'h000;
    end else if (clear_in) begin
      avg_q <= 10'h000;
    end else if (sample_valid_in && last_out) begin
      avg_q <= quot[RES_WIDTH-1:0];
    end
  end

endmodule

//--- gas_core_model.sv
// Converter core stand-in that answers each start with one sample
module gas_core_model
  import gas_pkg::*;
(
  input  wire logic                 mclk_in,
  input  wire logic                 arst_n_in,
  input  wire logic                 slow_in,
  input  wire logic                 conv_start_in,
  input  wire logic [4:0]           conv_channel_in,
  output logic                      sample_done_out,
  output logic [RES_WIDTH-1:0]      sample_data_out
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [2:0]           wait_q;
  logic [4:0]           idx_q;
  logic [RES_WIDTH-1:0] data_q;

  // Prompt or slow answer to each start
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wait_q <= 3'h0;
    end else if (conv_start_in) begin
      wait_q <= slow_in ? 3'h7 : 3'h1;
    end else if (wait_q != 3'h0) begin
      wait_q <= wait_q - 3'h1;
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      idx_q  <= 5'h00;
      data_q <= 10'h000;
    end else if (sample_done_out) begin
      idx_q  <= idx_q + 5'h01;
      data_q <= sample_data_out;
    end
  end

  assign sample_done_out = (wait_q == 3'h1);
  // Outside the valid cycle the data bus shows the inverse of the last value
  assign sample_data_out = sample_done_out ? {conv_channel_in, idx_q}
                                           : ~data_q;
endmodule

//--- gas_pkg.sv
// Constants, register map and types for the converter sequencer
package gas_pkg;

  // Register byte addresses
  localparam logic [11:0] ADDR_MAIN_CTRL = 12'hA00;
  localparam logic [11:0] ADDR_SW_SEL    = 12'hA01;
  localparam logic [11:0] ADDR_HW_SEL    = 12'hA02;
  localparam logic [11:0] ADDR_DELAY     = 12'hA03;
  localparam logic [11:0] ADDR_STATUS    = 12'hA04;
  localparam logic [11:0] ADDR_SW_RES_LO = 12'hA05;
  localparam logic [11:0] ADDR_SW_RES_HI = 12'hA06;
  localparam logic [11:0] ADDR_HW_RES_LO = 12'hA07;
  localparam logic [11:0] ADDR_HW_RES_HI = 12'hA08;

  // Main control bit positions
  localparam int BIT_CONV_EN   = 0;
  localparam int BIT_TRIG_EN   = 1;
  localparam int BIT_SW_LAUNCH = 2;
  localparam int BIT_PUP_FORCE = 3;
  localparam int BIT_EDGE_SEL  = 4;
  localparam int BIT_PUP_SUP   = 5;
  localparam int BIT_BUF_EN    = 6;
  localparam int BIT_ISENSE_EN = 7;

  // Select register fields
  localparam int CH_MSB  = 4;
  localparam int AVG_LSB = 5;
  localparam int AVG_MSB = 6;

  // Status and result fields
  localparam int BIT_BUSY   = 0;
  localparam int RES_WIDTH  = 10;
  localparam int SUM_WIDTH  = 14;

  // Reset value and write masks
  localparam logic [7:0] REG_RESET   = 8'h00;
  localparam logic [7:0] SEL_WR_MASK = 8'h7F;
  localparam logic [7:0] CTRL_WR_MASK = 8'hFB;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_STORE  = 2'b11
  } gas_state_t;

  // Averaging code to right-shift: 1, 4, 8 or 16 samples
  function automatic logic [2:0] gas_avg_shift(input logic [1:0] code);
    logic [2:0] s;
    case (code)
      2'h0:    s = 3'h0;
      2'h1:    s = 3'h2;
      2'h2:    s = 3'h3;
      default: s = 3'h4;
    endcase
    return s;
  endfunction

endpackage

//--- gas_sequencer.sv
// Converter sequencer: registers, trigger delay, launch and results
//
// Notes on behaviour
// - Converter usable only while enable bit set
// - Writing launch bit starts one software conversion
// - Trigger pin ignored unless trigger enable set
// - Edge select: 0 rising, 1 falling
// - Trigger delay is count of 32 kHz periods
// - Software averaging code gives 1/4/8/16 samples
// - Software channel field routes converter input
// - Triggered conversions use own channel field
// - Triggered conversions use own averaging field
// - Status bit 0 reads busy state
// - Software result split low byte, high bits
// - Triggered result kept in separate registers
// - Buffer enable bit drives channel buffer
// - Current-sense bit enables charge sense path
// - Pull-up force bit overrides charger control
// - Supply select acts only in temperature mode
// - Any of three resets clears registers
module gas_sequencer
  import gas_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        arst_n_in,
  input  wire logic        standard_register_reset_n_in,
  input  wire logic        digital_power_on_reset_n_in,
  input  wire logic        switch_off_reset_n_in,
  input  wire logic [11:0] reg_addr_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic [7:0]  reg_wdata_in,
  output logic [7:0]       reg_rdata_out,
  input  wire logic        conversion_trigger_pin_in,
  input  wire logic        slow_clk_in,
  input  wire logic        battery_temperature_mode_in,
  input  wire logic        sample_done_in,
  input  wire logic [9:0]  sample_data_in,
  output logic             conv_start_out,
  output logic [4:0]       conv_channel_out,
  output logic             converter_enable_out,
  output logic             channel_buffer_enable_out,
  output logic             charge_current_sense_enable_out,
  output logic             temperature_pullup_force_out,
  output logic             temperature_pullup_supply_select_out,
  output logic             conversion_in_progress_out
);

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!arst_n_in);

  logic       rst_std_s;
  logic       rst_por_s;
  logic       rst_off_s;
  logic       trig_s;
  logic       slow_s;
  logic       soft_clr;
  logic [7:0] ctrl_q;
  logic [7:0] sw_sel_q;
  logic [7:0] hw_sel_q;
  logic [7:0] delay_q;
  logic [9:0] sw_res_q;
  logic [9:0] hw_res_q;
  logic [7:0] rdata_q;
  logic       sw_pend_q;
  logic       hw_pend_q;
  logic       trig_prev_q;
  logic       slow_prev_q;
  logic       dly_act_q;
  logic [7:0] dly_cnt_q;
  gas_state_t state_q;
  logic       start_q;
  logic       src_hw_q;
  logic [4:0] ch_q;
  logic       conv_en;
  logic       trig_en;
  logic       sw_set;
  logic       trig_hit;
  logic       tick;
  logic       hw_fire;
  logic       take_sw;
  logic       take_hw;
  logic       take_any;
  logic       smp_valid;
  logic       avg_last;
  logic [9:0] avg_val;
  logic       busy;

  gas_sync u_sync_std (
    .mclk_in   (mclk_in),
    .arst_n_in (arst_n_in),
    .d_in      (standard_register_reset_n_in),
    .q_out     (rst_std_s)
  );
  gas_sync u_sync_por (
    .mclk_in   (mclk_in),
    .arst_n_in (arst_n_in),
    .d_in      (digital_power_on_reset_n_in),
    .q_out     (rst_por_s)
  );
  gas_sync u_sync_off (
    .mclk_in   (mclk_in),
    .arst_n_in (arst_n_in),
    .d_in      (switch_off_reset_n_in),
    .q_out     (rst_off_s)
  );
  gas_sync u_sync_trig (
    .mclk_in   (mclk_in),
    .arst_n_in (arst_n_in),
    .d_in      (conversion_trigger_pin_in),
    .q_out     (trig_s)
  );
  gas_sync u_sync_slow (
    .mclk_in   (mclk_in),
    .arst_n_in (arst_n_in),
    .d_in      (slow_clk_in),
    .q_out     (slow_s)
  );

  assign soft_clr = !(rst_std_s && rst_por_s && rst_off_s);

  assign conv_en = ctrl_q[BIT_CONV_EN];
  assign trig_en = ctrl_q[BIT_TRIG_EN] && conv_en;
  assign sw_set  = reg_wr_in && (reg_addr_in == ADDR_MAIN_CTRL)
                   && reg_wdata_in[BIT_SW_LAUNCH] && reg_wdata_in[BIT_CONV_EN];

  assign trig_hit  = trig_en && (trig_s != trig_prev_q)
                     && (trig_s != ctrl_q[BIT_EDGE_SEL]);
  assign tick      = slow_s && !slow_prev_q;

  assign hw_fire = trig_en && (trig_hit ? (delay_q == 8'h00)
                   : (dly_act_q && tick && (dly_cnt_q == 8'h01)));

  assign take_sw   = (state_q == ST_IDLE) && sw_pend_q && conv_en;
  assign take_hw   = (state_q == ST_IDLE) && !sw_pend_q && hw_pend_q
                     && conv_en;
  assign take_any  = take_sw || take_hw;
  assign smp_valid = (state_q == ST_SAMPLE) && sample_done_in;
  assign busy      = (state_q != ST_IDLE);

  // Register writes; launch bit never stored
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl_q   <= REG_RESET;
      sw_sel_q <= REG_RESET;
      hw_sel_q <= REG_RESET;
      delay_q  <= REG_RESET;
    end else if (soft_clr) begin
      ctrl_q   <= REG_RESET;
      sw_sel_q <= REG_RESET;
      hw_sel_q <= REG_RESET;
      delay_q  <= REG_RESET;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        ADDR_MAIN_CTRL: ctrl_q   <= reg_wdata_in & CTRL_WR_MASK;
        ADDR_SW_SEL:    sw_sel_q <= reg_wdata_in & SEL_WR_MASK;
        ADDR_HW_SEL:    hw_sel_q <= reg_wdata_in & SEL_WR_MASK;
        ADDR_DELAY:     delay_q  <= reg_wdata_in;
        default: begin
        end
      endcase
    end
  end

  // Edge history for trigger pin and slow clock
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      trig_prev_q <= 1'b0;
      slow_prev_q <= 1'b0;
    end else begin
      trig_prev_q <= trig_s;
      slow_prev_q <= slow_s;
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dly_act_q <= 1'b0;
      dly_cnt_q <= 8'h00;
    end else if (soft_clr || !trig_en) begin
      dly_act_q <= 1'b0;
      dly_cnt_q <= 8'h00;
    end else if (trig_hit) begin
      dly_act_q <= (delay_q != 8'h00);
      dly_cnt_q <= delay_q;
    end else if (dly_act_q && tick) begin
      dly_cnt_q <= dly_cnt_q - 8'h01;
      if (dly_cnt_q == 8'h01) begin
        dly_act_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sw_pend_q <= 1'b0;
      hw_pend_q <= 1'b0;
    end else if (soft_clr) begin
      sw_pend_q <= 1'b0;
      hw_pend_q <= 1'b0;
    end else begin
      sw_pend_q <= sw_set || (sw_pend_q && conv_en && !take_sw);
      hw_pend_q <= hw_fire || (hw_pend_q && conv_en && !take_hw);
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q <= ST_IDLE;
    end else if (soft_clr || !conv_en) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE:   if (take_any) state_q <= ST_SAMPLE;
        ST_SAMPLE: if (smp_valid && avg_last) state_q <= ST_STORE;
        ST_STORE:  state_q <= ST_IDLE;
        default:   state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      start_q  <= 1'b0;
      src_hw_q <= 1'b0;
      ch_q     <= 5'h00;
    end else if (soft_clr) begin
      start_q  <= 1'b0;
      src_hw_q <= 1'b0;
      ch_q     <= 5'h00;
    end else begin
      start_q <= take_any
                 || (smp_valid && !avg_last && conv_en);
      if (take_any) begin
        src_hw_q <= take_hw;
        ch_q     <= take_sw ? sw_sel_q[CH_MSB:0] : hw_sel_q[CH_MSB:0];
      end
    end
  end

  gas_averager u_avg (
    .mclk_in         (mclk_in),
    .arst_n_in       (arst_n_in),
    .clear_in        (soft_clr),
    .start_in        (take_any),
    .avg_code_in     (take_sw ? sw_sel_q[AVG_MSB:AVG_LSB]
                              : hw_sel_q[AVG_MSB:AVG_LSB]),
    .sample_valid_in (smp_valid),
    .sample_in       (sample_data_in),
    .last_out        (avg_last),
    .avg_out         (avg_val)
  );

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sw_res_q <= 10'h000;
      hw_res_q <= 10'h000;
    end else if (soft_clr) begin
      sw_res_q <= 10'h000;
      hw_res_q <= 10'h000;
    end else if (state_q == ST_STORE) begin
      if (src_hw_q) begin
        hw_res_q <= avg_val;
      end else begin
        sw_res_q <= avg_val;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_q <= REG_RESET;
    end else if (soft_clr) begin
      rdata_q <= REG_RESET;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        ADDR_MAIN_CTRL: rdata_q <= ctrl_q;
        ADDR_SW_SEL:    rdata_q <= sw_sel_q;
        ADDR_HW_SEL:    rdata_q <= hw_sel_q;
        ADDR_DELAY:     rdata_q <= delay_q;
        ADDR_STATUS:    rdata_q <= {7'h00, busy};
        ADDR_SW_RES_LO: rdata_q <= sw_res_q[7:0];
        ADDR_SW_RES_HI: rdata_q <= {6'h00, sw_res_q[9:8]};
        ADDR_HW_RES_LO: rdata_q <= hw_res_q[7:0];
        ADDR_HW_RES_HI: rdata_q <= {6'h00, hw_res_q[9:8]};
        default:        rdata_q <= 8'h00;
      endcase
    end
  end

  assign reg_rdata_out              = rdata_q;
  assign conv_start_out             = start_q;
  assign conv_channel_out           = ch_q;
  assign conversion_in_progress_out = busy;
  assign converter_enable_out = ctrl_q[BIT_CONV_EN];
  assign channel_buffer_enable_out = ctrl_q[BIT_BUF_EN];
  assign charge_current_sense_enable_out = ctrl_q[BIT_ISENSE_EN];
  assign temperature_pullup_force_out = ctrl_q[BIT_PUP_FORCE];
  assign temperature_pullup_supply_select_out =
    ctrl_q[BIT_PUP_SUP] && battery_temperature_mode_in;

  AST_NO_START_DISABLED: assert property (
    !$past(conv_en) |-> !conv_start_out)
    else $error("conversion started while disabled");
  AST_SW_LAUNCH: assert property (
    sw_set && !soft_clr |=> sw_pend_q)
    else $error("software launch not registered");
  AST_TRIG_GATED: assert property (
    $rose(hw_pend_q) |-> $past(ctrl_q[BIT_TRIG_EN]))
    else $error("triggered request without trigger enable");
  AST_EDGE_SEL: assert property (
    trig_hit |-> (trig_s != trig_prev_q)
                 && (trig_s == !ctrl_q[BIT_EDGE_SEL]))
    else $error("trigger accepted on wrong edge");
  AST_ZERO_DELAY: assert property (
    trig_hit && delay_q == 8'h00 && !soft_clr |=> hw_pend_q)
    else $error("zero delay trigger not pending next cycle");
  AST_DELAY_HOLD: assert property (
    dly_act_q && !tick && !trig_hit && trig_en && !soft_clr
      |=> $stable(dly_cnt_q))
    else $error("delay counter moved without slow tick");
  AST_SW_CHANNEL: assert property (
    conv_start_out && !src_hw_q && $rose(busy)
      |-> ch_q == $past(sw_sel_q[CH_MSB:0]))
    else $error("software channel not routed");
  AST_HW_CHANNEL: assert property (
    conv_start_out && src_hw_q && $rose(busy)
      |-> ch_q == $past(hw_sel_q[CH_MSB:0]))
    else $error("triggered channel not routed");
  AST_BUSY_READ: assert property (
    reg_rd_in && reg_addr_in == ADDR_STATUS && !soft_clr
      |=> reg_rdata_out == {7'h00, $past(busy)})
    else $error("status read does not show busy");
  AST_STORE_SW: assert property (
    state_q == ST_STORE && !src_hw_q && !soft_clr
      |=> sw_res_q == $past(avg_val) && !busy)
    else $error("software result not stored");
  AST_STORE_HW: assert property (
    state_q == ST_STORE && src_hw_q && !soft_clr
      |=> hw_res_q == $past(avg_val) && $stable(sw_res_q))
    else $error("triggered result not stored separately");
  AST_SOFT_CLEAR: assert property (
    soft_clr |=> ctrl_q == REG_RESET && delay_q == REG_RESET
                 && sw_res_q == 10'h000 && !busy)
    else $error("register reset did not clear");

endmodule

//--- gas_sync.sv
// Two flip-flop synchroniser for asynchronous inputs
module gas_sync
  import gas_pkg::*;
(
  input  wire logic mclk_in,
  input  wire logic arst_n_in,
  input  wire logic d_in,
  output logic      q_out
);

  logic meta_q;
  logic sync_q;

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= d_in;
      sync_q <= meta_q;
    end
  end

  assign q_out = sync_q;

endmodule

//--- general_adc_sequencer_tb.sv
// Self-checking bench for the converter sequencer
module general_adc_sequencer_tb
  import gas_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [2:0]  rsrc_n = 3'h7;
  logic [11:0] addr = 12'h000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  wdata = 8'h00;
  logic        pin = 1'b0;
  logic        slow_clk = 1'b0;
  logic        temp_mode = 1'b0;
  logic        core_slow = 1'b0;
  logic [7:0]  rdata;
  logic        done;
  logic [9:0]  sdata;
  logic        start;
  logic [4:0]  chan;
  logic        en;
  logic        buf_en;
  logic        sense;
  logic        pup;
  logic        sup;
  logic        busy;
  logic [4:0]  last_ch = 5'h00;
  logic [9:0]  sw_res = 10'h000;
  logic [4:0]  chs [4] = '{5'h01, 5'h11, 5'h0C, 5'h0E};
  int          starts = 0;
  int          s0;
  int          miscompares = 0;
  int          comparisons = 0;

  always #2.5 clk = ~clk;
  // Slow tick at 40 system cycles keeps delay runs short
  always #100 slow_clk = ~slow_clk;

  gas_sequencer dut_u (
    .mclk_in                              (clk),
    .arst_n_in                            (arst_n),
    .standard_register_reset_n_in         (rsrc_n[0]),
    .digital_power_on_reset_n_in          (rsrc_n[1]),
    .switch_off_reset_n_in                (rsrc_n[2]),
    .reg_addr_in                          (addr),
    .reg_wr_in                            (wr),
    .reg_rd_in                            (rd),
    .reg_wdata_in                         (wdata),
    .reg_rdata_out                        (rdata),
    .conversion_trigger_pin_in            (pin),
    .slow_clk_in                          (slow_clk),
    .battery_temperature_mode_in          (temp_mode),
    .sample_done_in                       (done),
    .sample_data_in                       (sdata),
    .conv_start_out                       (start),
    .conv_channel_out                     (chan),
    .converter_enable_out                 (en),
    .channel_buffer_enable_out            (buf_en),
    .charge_current_sense_enable_out      (sense),
    .temperature_pullup_force_out         (pup),
    .temperature_pullup_supply_select_out (sup),
    .conversion_in_progress_out           (busy)
  );

  gas_core_model core_u (
    .mclk_in         (clk),
    .arst_n_in       (arst_n),
    .slow_in         (core_slow),
    .conv_start_in   (start),
    .conv_channel_in (chan),
    .sample_done_out (done),
    .sample_data_out (sdata)
  );

  always @(posedge clk) begin
    if (start === 1'b1) begin
      starts  <= starts + 1;
      last_ch <= chan;
    end
  end

  task automatic give_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    cyc(1);
    addr = a;
    wdata = d;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
  endtask

  task automatic chk_reg(input string what, input logic [11:0] a,
                         input logic [7:0] exp);
    cyc(1);
    addr = a;
    rd = 1'b1;
    cyc(1);
    rd = 1'b0;
    chk(what, {8'h00, exp}, {8'h00, rdata});
  endtask

  task automatic wait_conv(input int from, input int bound);
    int n;
    n = 0;
    while ((starts == from || busy !== 1'b0) && n < bound) begin
      cyc(1);
      n++;
    end
    if (n >= bound) begin
      miscompares++;
      $display("wrong value conversion expected finish seen hang");
      give_verdict();
    end
  endtask

  function automatic logic [9:0] exp_avg(input logic [4:0] ch,
                                         input logic [4:0] i0,
                                         input logic [1:0] code);
    logic [13:0] sum;
    int          n;
    n = (code == 2'h0) ? 1 : (code == 2'h1) ? 4 : (code == 2'h2) ? 8 : 16;
    sum = 14'h0000;
    for (int k = 0; k < n; k++) begin
      sum = sum + {4'h0, ch, 5'(i0 + k)};
    end
    return 10'(sum / n);
  endfunction

  task automatic sw_conv(input logic [4:0] ch, input logic [1:0] code);
    logic [4:0] i0;
    int         b;
    i0 = core_u.idx_q;
    b = starts;
    wr_reg(ADDR_SW_SEL, {1'b0, code, ch});
    wr_reg(ADDR_MAIN_CTRL, 8'h05);
    cyc(1);
    chk_reg("busy", ADDR_STATUS, 8'h01);
    wait_conv(b, 3000);
    sw_res = exp_avg(ch, i0, code);
    chk("sw channel", {11'h000, ch}, {11'h000, last_ch});
    chk_reg("sw low", ADDR_SW_RES_LO, sw_res[7:0]);
    chk_reg("sw high", ADDR_SW_RES_HI, {6'h00, sw_res[9:8]});
    chk_reg("idle", ADDR_STATUS, 8'h00);
  endtask

  task automatic hw_conv(input logic fall, input logic [7:0] dly,
                         input logic [4:0] ch, input logic [1:0] code);
    logic [4:0] i0;
    logic [9:0] e;
    int         b;
    wr_reg(ADDR_MAIN_CTRL, 8'h01);
    pin = ~fall;
    wr_reg(ADDR_HW_SEL, {1'b0, code, ch});
    wr_reg(ADDR_DELAY, dly);
    wr_reg(ADDR_MAIN_CTRL, {3'h0, fall, 4'h3});
    i0 = core_u.idx_q;
    b = starts;
    pin = fall;
    cyc(30);
    chk("wrong edge", 16'(b), 16'(starts));
    pin = ~fall;
    cyc(dly == 8'h00 ? 12 : 70);
    chk("delay", 16'(dly != 8'h00), 16'(starts == b));
    wait_conv(b, 200);
    e = exp_avg(ch, i0, code);
    chk("hw channel", {11'h000, ch}, {11'h000, last_ch});
    chk_reg("hw low", ADDR_HW_RES_LO, e[7:0]);
    chk_reg("hw high", ADDR_HW_RES_HI, {6'h00, e[9:8]});
    chk_reg("sw kept", ADDR_SW_RES_LO, sw_res[7:0]);
  endtask

  initial begin
    cyc(4);
    arst_n = 1'b1;
    cyc(3);
    for (int a = 0; a < 10; a++) begin
      chk_reg("reset", ADDR_MAIN_CTRL + 12'(a), 8'h00);
    end
    wr_reg(ADDR_MAIN_CTRL, 8'hE9);
    cyc(2);
    chk("pins", 16'h001E, {11'h000, en, buf_en, sense, pup, sup});
    temp_mode = 1'b1;
    cyc(1);
    chk("supply", 16'h0001, {15'h0000, sup});
    temp_mode = 1'b0;
    chk_reg("control", ADDR_MAIN_CTRL, 8'hE9);
    wr_reg(ADDR_SW_SEL, 8'hFF);
    chk_reg("sw select", ADDR_SW_SEL, 8'h7F);
    wr_reg(ADDR_HW_SEL, 8'hFF);
    chk_reg("hw select", ADDR_HW_SEL, 8'h7F);
    wr_reg(ADDR_DELAY, 8'hA5);
    chk_reg("delay", ADDR_DELAY, 8'hA5);
    wr_reg(ADDR_STATUS, 8'hFF);
    chk_reg("status", ADDR_STATUS, 8'h00);
    wr_reg(ADDR_SW_RES_LO, 8'hFF);
    chk_reg("result ro", ADDR_SW_RES_LO, 8'h00);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      core_slow = i[0];
      sw_conv(chs[i], 2'(i));
    end
    chk_reg("launch", ADDR_MAIN_CTRL, 8'h01);
    $display("test software done");
    hw_conv(1'b0, 8'h00, 5'h0E, 2'h1);
    hw_conv(1'b1, 8'h03, 5'h09, 2'h2);
    $display("test trigger done");
    wr_reg(ADDR_MAIN_CTRL, 8'h01);
    s0 = starts;
    pin = ~pin;
    cyc(10);
    pin = ~pin;
    cyc(50);
    chk("trigger off", 16'(s0), 16'(starts));
    wr_reg(ADDR_MAIN_CTRL, 8'h04);
    cyc(30);
    chk("disabled", 16'(s0), 16'(starts));
    chk("enable", 16'h0000, {15'h0000, en});
    $display("test disable done");
    for (int i = 0; i < 3; i++) begin
      wr_reg(ADDR_MAIN_CTRL, 8'hC9);
      wr_reg(ADDR_DELAY, 8'h5A);
      rsrc_n[i] = 1'b0;
      cyc(5);
      rsrc_n[i] = 1'b1;
      cyc(4);
      chk_reg("ctrl clear", ADDR_MAIN_CTRL, 8'h00);
      chk_reg("delay clear", ADDR_DELAY, 8'h00);
      chk_reg("hw clear", ADDR_HW_RES_LO, 8'h00);
      chk("enable clear", 16'h0000, {15'h0000, en});
    end
    $display("test reset sources done");
    give_verdict();
  end
endmodule
